// >>> tt_core.sv
// Function
// R1: 16-bit count as low and high bytes
// R2: timer function counts once per machine cycle
// R3: count input sampled per cycle, counts falls
// R4: new count appears at next update slot
// R5: events counted at most every two cycles
// R6: source holds each level one machine cycle
// R7: run, serial selects, capture select pick mode
// R8: counter/timer select picks clock source
// R9: control register layout, resets to zero
// R10: overflow flag sticky, cleared by software
// R11: no overflow flag while serial selects set
// R12: trigger fall with enable sets external flag; not in up/down mode, where overflow toggles it
// R13: external flag requests interrupt, software clears
// R14: no external flag interrupt in up/down mode
// R15: receive clock from this or other timer
// R16: transmit clock from this or other timer
// R17: trigger fall captures count into reload pair
// R18: auto-reload loads reload pair on overflow
// R19: down count underflows at reload, loads FFFF
// R20: trigger ignored while external enable clear; up/down mode still reads it as count direction
// R21: baud mode emits overflow pulse to serial
// R22: pins synchronised before edge detection
`timescale 1ns/1ps
`default_nettype none
module tt_core (
	input  wire logic          SYS_CLK_I,
	input  wire logic          ARST_N_I,
	input  wire logic          PSEL_I,
	input  wire logic          PENABLE_I,
	input  wire logic          PWRITE_I,
	input  wire logic [7:0]    PADDR_I,
	input  wire logic [31:0]   PWDATA_I,
	output logic      [31:0]   PRDATA_O,
	output logic               PREADY_O,
	output logic               PSLVERR_O,
	input  wire logic          COUNT_PIN_I,
	input  wire logic          TRIGGER_PIN_I,
	input  wire logic          OTHER_TIMER_OVF_I,
	output logic               TIMER_IRQ_O,
	output logic               BAUD_TICK_O,
	output logic               RX_CLK_TICK_O,
	output logic               TX_CLK_TICK_O
);
	import tt_pkg::*;

	logic [7:0]  ctrl_r;
	logic        up_down_enable_r;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [15:0] reload_r;
	logic [3:0]  ph_r;
	logic        cnt_meta_r, cnt_sync_r, cnt_smp_r, cnt_pend_r;
	logic        trg_meta_r, trg_sync_r, trg_smp_r, trg_pend_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;
	logic        setup, acc, wr_en;
	logic        ctrl_wr, mode_wr, count_wr, reload_wr;
	logic        upd, tick, down, ovf_up, unf, ovf, ext;
	logic        cap_evt, tf_set, exf_set, exf_tog, serial;
	tt_mode_type mode;

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == ADDR_CTRL) || (a == ADDR_MODE) ||
			(a == ADDR_COUNT) || (a == ADDR_RELOAD);
	endfunction : addr_hit

	function automatic tt_mode_type mode_of(input logic [7:0] c);
		if (!c[B_RUN]) begin
			mode_of = MODE_OFF;
		end else if (c[B_RCLK] || c[B_TRANSMIT_CLOCK_SELECT]) begin
			mode_of = MODE_BAUD;
		end else if (c[B_CPRL]) begin
			mode_of = MODE_CAPTURE;
		end else begin
			mode_of = MODE_RELOAD;
		end
	endfunction : mode_of

	// apb slave: one setup, one access cycle, no wait states
	assign setup     = PSEL_I & ~PENABLE_I;
	assign acc       = PSEL_I & PENABLE_I & pready_r;
	assign wr_en     = acc & PWRITE_I & ~pslverr_r;
	assign ctrl_wr   = wr_en && (PADDR_I == ADDR_CTRL);
	assign mode_wr   = wr_en && (PADDR_I == ADDR_MODE);
	assign count_wr  = wr_en && (PADDR_I == ADDR_COUNT);
	assign reload_wr = wr_en && (PADDR_I == ADDR_RELOAD);

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~addr_hit(PADDR_I);
			if (setup) begin
				case (PADDR_I)
					ADDR_CTRL:   prdata_r <= {24'h000000, ctrl_r};
					ADDR_MODE:   prdata_r <= {31'h00000000, up_down_enable_r};
					ADDR_COUNT:  prdata_r <= {16'h0000, count_r};
					ADDR_RELOAD: prdata_r <= {16'h0000, reload_r};
					default:     prdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// machine cycle phase, 12 oscillator periods
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ph_r <= 4'h0;
		end else if (ph_r == MC_LAST) begin
			ph_r <= 4'h0;
		end else begin
			ph_r <= ph_r + 4'h1;
		end
	end

	// two-flop synchronisers, updated on every rising clock edge
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cnt_meta_r <= 1'b0;
			cnt_sync_r <= 1'b0;
			trg_meta_r <= 1'b0;
			trg_sync_r <= 1'b0;
		end else begin
			cnt_meta_r <= COUNT_PIN_I;   // [R22]
			cnt_sync_r <= cnt_meta_r;
			trg_meta_r <= TRIGGER_PIN_I; // [R22]
			trg_sync_r <= trg_meta_r;
		end
	end

	// a fall is seen only across two samples, which caps the rate
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cnt_smp_r  <= 1'b0;
			cnt_pend_r <= 1'b0;
			trg_smp_r  <= 1'b0;
			trg_pend_r <= 1'b0;
		end else if (ph_r == SAMPLE_SLOT) begin
			cnt_smp_r  <= cnt_sync_r;                // [R3] [R5]
			cnt_pend_r <= cnt_smp_r & ~cnt_sync_r;   // [R3]
			trg_smp_r  <= trg_sync_r;
			trg_pend_r <= trg_smp_r & ~trg_sync_r;
		end else if (upd) begin
			cnt_pend_r <= 1'b0;                      // [R4]
			trg_pend_r <= 1'b0;
		end
	end

	assign upd    = (ph_r == UPDATE_SLOT);
	assign mode   = mode_of(ctrl_r);                              // [R7]
	assign serial = ctrl_r[B_RCLK] | ctrl_r[B_TRANSMIT_CLOCK_SELECT];
	assign tick   = upd && (mode != MODE_OFF) &&
		(ctrl_r[B_CT] ? cnt_pend_r : 1'b1);                   // [R2] [R8]
	assign down   = up_down_enable_r && !trg_sync_r && (mode == MODE_RELOAD);
	assign ovf_up = tick && !down && (count_r == COUNT_MAX);
	assign unf    = tick && down && (count_r == reload_r);      // [R19]
	assign ovf    = ovf_up | unf;
	// a trigger fall only acts with external enable set
	assign ext    = upd && trg_pend_r && ctrl_r[B_EXEN] &&
		(mode != MODE_OFF);                                   // [R20]
	assign cap_evt = ext && (mode == MODE_CAPTURE);             // [R17]
	assign tf_set  = ovf && !serial;                            // [R10] [R11]
	assign exf_tog = ovf && up_down_enable_r && (mode == MODE_RELOAD);
	assign exf_set = ext && !(up_down_enable_r && (mode == MODE_RELOAD)); // [R12]

	always_comb begin
		count_nxt = count_r;
		case (mode)
			MODE_CAPTURE: begin
				if (tick) begin
					count_nxt = count_r + 16'h0001;
				end
			end
			MODE_RELOAD, MODE_BAUD: begin
				if (ovf_up) begin
					count_nxt = reload_r;                 // [R18]
				end else if (unf) begin
					count_nxt = COUNT_MAX;                // [R19]
				end else if (tick && down) begin
					count_nxt = count_r - 16'h0001;
				end else if (tick) begin
					count_nxt = count_r + 16'h0001;       // [R1]
				end
				// the serial clock owns the reload in baud mode
				if (ext && !up_down_enable_r && (mode == MODE_RELOAD)) begin
					count_nxt = reload_r;
				end
			end
			default: begin
				count_nxt = count_r;
			end
		endcase
	end

	// software write to the count wins over the hardware update
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			count_r <= COUNT_RST;
		end else if (count_wr) begin
			count_r <= PWDATA_I[15:0];
		end else begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			reload_r <= RELOAD_RST;
		end else if (cap_evt) begin
			reload_r <= count_r;                          // [R17]
		end else if (reload_wr) begin
			reload_r <= PWDATA_I[15:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			up_down_enable_r <= MODE_RST;
		end else if (mode_wr) begin
			up_down_enable_r <= PWDATA_I[B_UP_DOWN_ENABLE];
		end
	end

	// flags: hardware set beats a software clear in the same cycle
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ctrl_r <= CTRL_RST;                           // [R9]
		end else begin
			if (ctrl_wr) begin
				ctrl_r <= PWDATA_I[7:0];
			end
			if (tf_set) begin
				ctrl_r[B_TF] <= 1'b1;                     // [R10]
			end
			if (exf_set) begin
				ctrl_r[B_EXF] <= 1'b1;                    // [R12] [R13]
			end else if (exf_tog) begin
				ctrl_r[B_EXF] <= ctrl_wr ? ~PWDATA_I[B_EXF] :
					~ctrl_r[B_EXF];
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			TIMER_IRQ_O   <= 1'b0;
			BAUD_TICK_O   <= 1'b0;
			RX_CLK_TICK_O <= 1'b0;
			TX_CLK_TICK_O <= 1'b0;
		end else begin
			TIMER_IRQ_O   <= ctrl_r[B_TF] |
				(ctrl_r[B_EXF] & ~up_down_enable_r);                // [R13] [R14]
			BAUD_TICK_O   <= ovf && (mode == MODE_BAUD);  // [R21]
			RX_CLK_TICK_O <= ctrl_r[B_RCLK] ?
				(ovf && (mode == MODE_BAUD)) : OTHER_TIMER_OVF_I; // [R15]
			TX_CLK_TICK_O <= ctrl_r[B_TRANSMIT_CLOCK_SELECT] ?
				(ovf && (mode == MODE_BAUD)) : OTHER_TIMER_OVF_I; // [R16]
		end
	end

	assign PRDATA_O  = prdata_r;
	assign PREADY_O  = pready_r;
	assign PSLVERR_O = pslverr_r;

	chk_timer_step: assert property ( // [R2]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		upd && mode == MODE_CAPTURE && !ctrl_r[B_CT] && !count_wr
		|=> count_r == $past(count_r) + 16'h0001)
		else $error("timer did not step at update slot");
	chk_count_hold: assert property ( // [R4]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		!upd && !count_wr |=> $stable(count_r))
		else $error("count moved outside update slot");
	chk_fall_seen: assert property ( // [R3]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		ph_r == SAMPLE_SLOT && cnt_smp_r && !cnt_sync_r
		|=> cnt_pend_r ##6 (upd && cnt_pend_r))
		else $error("falling count edge lost before update");
	chk_off_hold: assert property ( // [R7]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		!ctrl_r[B_RUN] && !count_wr |=> $stable(count_r))
		else $error("count moved while stopped");
	chk_tf_sticky: assert property ( // [R10]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		ctrl_r[B_TF] && !ctrl_wr |=> ctrl_r[B_TF])
		else $error("overflow flag cleared by hardware");
	chk_tf_suppress: assert property ( // [R11]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		serial && !ctrl_r[B_TF] && !ctrl_wr |=> !ctrl_r[B_TF])
		else $error("overflow flag set in serial clock mode");
	chk_exf_ignore: assert property ( // [R20]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		!ctrl_r[B_EXEN] && !ctrl_r[B_EXF] && !ctrl_wr && !up_down_enable_r
		|=> !ctrl_r[B_EXF])
		else $error("external flag set with enable clear");
	chk_irq_updown: assert property ( // [R14]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		(up_down_enable_r && !ctrl_r[B_TF]) [*2] |-> !TIMER_IRQ_O)
		else $error("interrupt from external flag in up/down mode");
	chk_capture: assert property ( // [R17]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		cap_evt |=> reload_r == $past(count_r) && ctrl_r[B_EXF])
		else $error("capture did not copy count");
	chk_reload_ovf: assert property ( // [R18]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		ovf_up && mode != MODE_CAPTURE && !count_wr
		|=> count_r == $past(reload_r))
		else $error("overflow did not reload");
	chk_underflow: assert property ( // [R19]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		unf && !count_wr |=> count_r == COUNT_MAX && ctrl_r[B_TF])
		else $error("underflow did not load all ones");
	chk_baud_pulse: assert property ( // [R21]
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		BAUD_TICK_O |=> !BAUD_TICK_O [*8])
		else $error("baud pulse longer than one cycle");

	cov_capture: cover property (
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I) cap_evt);
	cov_underflow: cover property (
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I) unf);
	cov_baud: cover property (
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I) BAUD_TICK_O);
	cov_event_count: cover property (
		@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
		tick && ctrl_r[B_CT]);

endmodule : tt_core
`default_nettype wire

// >>> tt_pkg.sv
package tt_pkg;

	// register byte addresses on the bus
	localparam logic [7:0]  ADDR_CTRL     = 8'hC8;
	localparam logic [7:0]  ADDR_MODE     = 8'hCC;
	localparam logic [7:0]  ADDR_COUNT    = 8'hD0;
	localparam logic [7:0]  ADDR_RELOAD   = 8'hD4;

	// timer2_control bit positions
	localparam int          B_TF          = 7;
	localparam int          B_EXF         = 6;
	localparam int          B_RCLK        = 5;
	localparam int          B_TRANSMIT_CLOCK_SELECT        = 4;
	localparam int          B_EXEN        = 3;
	localparam int          B_RUN         = 2;
	localparam int          B_CT          = 1;
	localparam int          B_CPRL        = 0;
	// mode register bit position
	localparam int          B_UP_DOWN_ENABLE        = 0;

	// reset values and the count maximum
	localparam logic [7:0]  CTRL_RST      = 8'h00;
	localparam logic [0:0]  MODE_RST      = 1'h0;
	localparam logic [15:0] COUNT_RST     = 16'h0000;
	localparam logic [15:0] RELOAD_RST    = 16'h0000;
	localparam logic [15:0] COUNT_MAX     = 16'hFFFF;

	// machine cycle timing, in oscillator periods
	localparam logic [3:0]  MC_LAST       = 4'hB;
	localparam logic [3:0]  SAMPLE_SLOT   = 4'h9;
	localparam logic [3:0]  UPDATE_SLOT   = 4'h4;

	typedef enum logic [1:0] {
		MODE_OFF     = 2'b00,
		MODE_RELOAD  = 2'b01,
		MODE_CAPTURE = 2'b10,
		MODE_BAUD    = 2'b11
	} tt_mode_type;

endpackage : tt_pkg

// >>> tt_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module tt_far_model (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic run_i,
	output logic      pin_o,
	output logic      ovf_o
);
	logic [4:0] hold_r;
	logic [3:0] ovf_r;
	// each level held exactly one machine cycle: fastest legal source
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_r <= 5'h00;
			pin_o  <= 1'b1;
		end else if (run_i) begin
			hold_r <= (hold_r == 5'h0B) ? 5'h00 : hold_r + 5'h01;
			if (hold_r == 5'h0B)
				pin_o <= ~pin_o;
		end
	end
	// other timer overflow, one pulse every 16 clocks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovf_r <= 4'h0;
			ovf_o <= 1'b0;
		end else begin
			ovf_r <= ovf_r + 4'h1;
			ovf_o <= (ovf_r == 4'hF);
		end
	end
endmodule : tt_far_model
`default_nettype wire

// >>> tt_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tt_core_tb;
	import tt_pkg::*;
	localparam logic [31:0] K_RUN = 32'h1 << B_RUN;
	logic        clk, rst_n, psel, pen, pwr, trig, src, perr_s;
	logic [7:0]  padr;
	logic [31:0] pwd, prd, q, rv, c;
	logic        prdy, perr, cpin, oth, irq, baud, rxt, txt;
	int          seed, mismatches, num_checks, nrx, noth, ntx, a, b;
	int          nbd, t0, b0;
	tt_core i_dut (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
		.PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
		.COUNT_PIN_I(cpin), .TRIGGER_PIN_I(trig), .OTHER_TIMER_OVF_I(oth),
		.TIMER_IRQ_O(irq), .BAUD_TICK_O(baud), .RX_CLK_TICK_O(rxt),
		.TX_CLK_TICK_O(txt));
	tt_far_model i_far (.clk_i(clk), .rst_n_i(rst_n), .run_i(src),
		.pin_o(cpin), .ovf_o(oth));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		nrx  <= nrx + int'(rxt === 1'b1);
		noth <= noth + int'(oth === 1'b1);
		ntx  <= ntx + int'(txt === 1'b1);
		nbd  <= nbd + int'(baud === 1'b1);
	end
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		psel <= 1'b1;
		pen  <= 1'b0;
		pwr  <= w;
		padr <= ad;
		pwd  <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		q = prd;
		perr_s = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
		// idle edge: the next call must not re-raise psel in this step
		@(posedge clk);
	endtask : apb
	task automatic chk(input logic [31:0] g, input logic [31:0] lo,
		input logic [31:0] hi);
		num_checks++;
		if (!(g >= lo && g <= hi) || $isunknown(g)) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
		end
	endtask : chk
	function automatic logic [31:0] mcs(input int n);
		return n / 12;
	endfunction : mcs
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	initial begin
		#200000;
		mismatches++;
		final_report();
	end
	initial begin
		seed = 32'h775562DF;
		{psel, pen, pwr, padr, pwd, src, rst_n} = '0;
		{mismatches, num_checks, nrx, noth, ntx, nbd} = '0;
		trig = 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(0, ADDR_CTRL, 0); chk(q, CTRL_RST, CTRL_RST);
		apb(0, ADDR_COUNT, 0); chk(q, 0, 0);
		apb(0, 8'hF0, 0); chk({31'h0, perr_s}, 1, 1);
		apb(1, ADDR_CTRL, K_RUN);
		repeat (120) @(posedge clk);
		apb(1, ADDR_CTRL, 0);
		apb(0, ADDR_COUNT, 0); chk(q, mcs(122), mcs(122) + 1);
		rv = $random(seed) & 32'h7FFF;
		apb(1, ADDR_RELOAD, rv);
		apb(1, ADDR_COUNT, 32'hFFFE);
		apb(1, ADDR_CTRL, K_RUN);
		repeat (36) @(posedge clk);
		apb(0, ADDR_CTRL, 0); chk(q[B_TF], 1, 1);
		apb(0, ADDR_COUNT, 0); chk(q, rv, rv + 3);
		chk({31'h0, irq}, 1, 1);
		repeat (24) @(posedge clk);
		apb(0, ADDR_CTRL, 0); chk(q[B_TF], 1, 1);
		apb(1, ADDR_CTRL, K_RUN);
		apb(0, ADDR_CTRL, 0); chk(q[B_TF], 0, 0);
		apb(1, ADDR_COUNT, 32'hFFFE);
		a = nrx - noth;
		t0 = ntx;
		b0 = nbd;
		apb(1, ADDR_CTRL, K_RUN | (32'h1 << B_TRANSMIT_CLOCK_SELECT));
		repeat (60) @(posedge clk);
		apb(0, ADDR_CTRL, 0); chk(q[B_TF], 0, 0);
		// one own overflow, plus at most one other-timer pulse before switch
		chk(ntx - t0, 1, 2);
		chk(nbd - b0, 1, 1);
		b = nrx - noth;
		chk(b - a + 1, 0, 2);
		apb(1, ADDR_COUNT, 32'hFFFE);
		t0 = nrx;
		apb(1, ADDR_CTRL, K_RUN | (32'h1 << B_RCLK));
		repeat (60) @(posedge clk);
		chk(nrx - t0, 1, 2);
		apb(1, ADDR_CTRL, 0);
		apb(1, ADDR_COUNT, 0);
		src <= 1'b1;
		apb(1, ADDR_CTRL, K_RUN | (32'h1 << B_CT));
		repeat (240) @(posedge clk);
		apb(1, ADDR_CTRL, 0);
		apb(0, ADDR_COUNT, 0); chk(q, 9, 11);
		apb(1, ADDR_CTRL, K_RUN | (32'h1 << B_EXEN) | (32'h1 << B_CPRL));
		repeat (30) @(posedge clk);
		trig <= 1'b0;
		repeat (30) @(posedge clk);
		apb(0, ADDR_CTRL, 0); chk(q[B_EXF], 1, 1);
		apb(0, ADDR_COUNT, 0);
		c = q;
		apb(0, ADDR_RELOAD, 0); chk(q, c - 5, c);
		chk({31'h0, irq}, 1, 1);
		apb(1, ADDR_MODE, 32'h1 << B_UP_DOWN_ENABLE);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 0, 0);
		apb(1, ADDR_MODE, 0);
		trig <= 1'b1;
		apb(1, ADDR_CTRL, K_RUN | (32'h1 << B_CPRL));
		repeat (30) @(posedge clk);
		trig <= 1'b0;
		repeat (30) @(posedge clk);
		apb(0, ADDR_CTRL, 0); chk(q[B_EXF], 0, 0);
		rv = ($random(seed) & 32'h7FFF) + 32'h10;
		apb(1, ADDR_CTRL, 0);
		apb(1, ADDR_MODE, 32'h1 << B_UP_DOWN_ENABLE);
		apb(1, ADDR_RELOAD, rv);
		apb(1, ADDR_COUNT, rv + 2);
		apb(1, ADDR_CTRL, K_RUN);
		repeat (60) @(posedge clk);
		apb(0, ADDR_CTRL, 0); chk(q[B_TF], 1, 1);
		apb(0, ADDR_COUNT, 0); chk(q, 32'hFFFA, 32'hFFFF);
		final_report();
	end
endmodule : tt_core_tb
`default_nettype wire
